// ===== core/ptd_core.sv
// pulse duration gating and timing error supervision with avalon slave
`timescale 1ns/1ps
module ptd_core
  import ptd_pkg::*;
#(
  parameter int unsigned ERR_HOLD_CYC = HOLD_CYC_DEF,
  parameter int unsigned TT_HOLD_CYC  = HOLD_CYC_DEF,
  parameter int          DRV_DLY      = DRV_DLY_DEF,
  parameter int          LEN_W        = LEN_W_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        trig_in,
  input  wire logic        ramp_off_side,
  output logic             dur_out,
  output logic             dur_out_n,
  output logic             error_lamp,
  output logic             irq
);

  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a == o);
  endfunction : hit

  ptd_ctrl_t          ctrl;
  ptd_evt_t           status;
  ptd_evt_t           mask;
  ptd_evt_t           ev;
  ptd_state_t         state;
  logic [LEN_W-1:0]   dly_len;
  logic [LEN_W-1:0]   dur_len;
  logic [LEN_W-1:0]   dly_cnt;
  logic [LEN_W-1:0]   dur_cnt;
  logic               ack;
  logic               we;
  logic               dly_act;
  logic               dly_start;
  logic               dly_end;
  logic               dur_act;
  logic               dur_trig;
  logic               cfg_err;
  logic               cfg_q;
  logic               sup_en;
  logic               overlap;
  logic               err_latch;
  logic               sup_rst;
  logic [HOLD_W-1:0]  err_tmr;
  logic [DRV_DLY-1:0] drv_sr;
  logic               drv_q;
  logic               drv_rise;
  logic               drv_fall;
  logic               trail_err;
  logic               lead_err;
  logic               lead_set;
  logic               tt_rst;
  logic [HOLD_W-1:0]  tt_tmr;

  // bus: one wait cycle on every access, so read data is always ready
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign we              = avs_write & ack;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl    <= CTRL_RST;
      dly_len <= '0;
      dur_len <= '0;
      mask    <= MASK_RST;
    end else if (we) begin
      if (hit(avs_address, CTRL_OFS)) begin
        ctrl <= avs_writedata[2:0];
      end
      if (hit(avs_address, DLY_LEN_OFS)) begin
        dly_len <= avs_writedata[LEN_W-1:0];
      end
      if (hit(avs_address, DUR_LEN_OFS)) begin
        dur_len <= avs_writedata[LEN_W-1:0];
      end
      if (hit(avs_address, MASK_OFS)) begin
        mask <= avs_writedata[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read & ~ack) begin
      unique case (avs_address)
        CTRL_OFS:    avs_readdata <= {29'h0, ctrl};
        DLY_LEN_OFS: avs_readdata <= 32'(dly_len);
        DUR_LEN_OFS: avs_readdata <= 32'(dur_len);
        STATUS_OFS:  avs_readdata <= {28'h0, status};
        MASK_OFS:    avs_readdata <= {28'h0, mask};
        STATE_OFS:   avs_readdata <= {25'h0, state};
        default:     avs_readdata <= 32'h0;
      endcase
    end
  end

  assign state = '{dly_act: dly_act, dur_act: dur_act,
                   error_lamp: error_lamp, trail_err: trail_err,
                   lead_err: lead_err, overlap: overlap,
                   err_latch: err_latch};

  // sticky events; a new event wins over a write-one clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status <= '0;
    end else if (we && hit(avs_address, STATUS_OFS)) begin
      status <= (status & ~ptd_evt_t'(avs_writedata[3:0])) | ev;
    end else begin
      status <= status | ev;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // delay stage; a trigger during an active delay is not restarted
  assign dly_act   = (dly_cnt != '0);
  assign dly_start = trig_in & ~dly_act;
  assign dly_end   = (dly_cnt == LEN_W'(1));
  assign dur_trig  = (ctrl.undelayed_select & dly_start)
                   | (ctrl.delayed_select & dly_end);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dly_cnt <= '0;
    end else if (dly_start) begin
      dly_cnt <= dly_len;
    end else if (dly_act) begin
      dly_cnt <= dly_cnt - LEN_W'(1);
    end
  end

  // duration one-shot retriggers, so the overlap never silences it
  assign dur_act = (dur_cnt != '0);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dur_cnt <= '0;
    end else if (dur_trig) begin
      dur_cnt <= dur_len;
    end else if (dur_act) begin
      dur_cnt <= dur_cnt - LEN_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dur_out   <= 1'b0;
      dur_out_n <= 1'b0;
    end else begin
      dur_out   <= dur_act & ~ctrl.dur_gate;
      dur_out_n <= ~dur_act & ~ctrl.dur_gate;
    end
  end

  // settings that cannot produce a sensible pulse
  assign cfg_err = ~(ctrl.undelayed_select | ctrl.delayed_select)
                 | (dur_len == '0)
                 | (ctrl.delayed_select & (dly_len == '0));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_q <= 1'b0;
    end else begin
      cfg_q <= cfg_err;
    end
  end

  // duration and delay supervision
  assign sup_en  = ~err_latch;
  assign sup_rst = err_latch
                 & (err_tmr == HOLD_W'(ERR_HOLD_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (srst || sup_rst) begin
      overlap <= 1'b0;
    end else if (sup_en && dur_trig) begin
      overlap <= dur_act;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || sup_rst) begin
      err_latch <= 1'b0;
    end else if (overlap) begin
      err_latch <= 1'b1;
    end else if (sup_en && trig_in && dly_act) begin
      err_latch <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !err_latch || sup_rst) begin
      err_tmr <= '0;
    end else begin
      err_tmr <= err_tmr + HOLD_W'(1);
    end
  end

  // drive delayed to line up with the ramp it is compared against
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      drv_sr <= '0;
      drv_q  <= 1'b0;
    end else begin
      // gated output, so a blocked pulse is never judged against a ramp
      drv_sr <= {drv_sr[DRV_DLY-2:0], dur_out};
      drv_q  <= drv_sr[DRV_DLY-1];
    end
  end

  assign drv_rise = drv_sr[DRV_DLY-1] & ~drv_q;
  assign drv_fall = ~drv_sr[DRV_DLY-1] & drv_q;
  assign tt_rst   = lead_err
                  & (tt_tmr == HOLD_W'(TT_HOLD_CYC - 1));
  assign lead_set = (drv_fall & ramp_off_side) | trail_err;

  always_ff @(posedge ref_clk) begin
    if (srst || tt_rst) begin
      trail_err <= 1'b0;
    end else if (drv_rise && !ramp_off_side) begin
      trail_err <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || tt_rst) begin
      lead_err <= 1'b0;
    end else if (lead_set) begin
      lead_err <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !lead_err || tt_rst) begin
      tt_tmr <= '0;
    end else begin
      tt_tmr <= tt_tmr + HOLD_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      error_lamp <= 1'b0;
    end else begin
      error_lamp <= err_latch | lead_err | cfg_err;
    end
  end

  assign ev.overlap = sup_en & dur_trig & dur_act;
  assign ev.delay   = sup_en & trig_in & dly_act;
  assign ev.trans   = lead_set & ~lead_err & ~tt_rst;
  assign ev.cfg     = cfg_err & ~cfg_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  dur_start_a: assert property (
    dur_trig |=> dur_cnt == $past(dur_len))
    else $error("duration one-shot not loaded on trigger");
  gate_block_a: assert property (
    ctrl.dur_gate |=> !dur_out && !dur_out_n)
    else $error("duration output passed while gated");
  overlap_cap_a: assert property (
    sup_en && dur_trig && dur_act && !sup_rst |=> overlap ##1 err_latch)
    else $error("overlap not captured into latch");
  hold_off_a: assert property (
    err_latch && !overlap |=> !overlap)
    else $error("overlap flop took a trigger while latched");
  self_reset_a: assert property (
    $rose(err_latch) |-> err_latch [*8])
    else $error("error latch cleared too early");
  timer_end_a: assert property (
    sup_rst |=> !err_latch && !overlap && err_tmr == '0)
    else $error("supervisory flops not reset at terminal count");
  delay_err_a: assert property (
    sup_en && trig_in && dly_act && !sup_rst |=> err_latch ##1 error_lamp)
    else $error("delay overrun did not set latch");
  trans_lamp_a: assert property (
    lead_err |=> error_lamp)
    else $error("transition error did not light lamp");
  cfg_lamp_a: assert property (
    cfg_err |=> error_lamp)
    else $error("bad settings did not light lamp");
  drive_delay_a: assert property (
    !$past(srst, DRV_DLY) |-> drv_sr[DRV_DLY-1] == $past(dur_out, DRV_DLY))
    else $error("transition drive latency wrong");
  lead_cap_a: assert property (
    drv_fall && ramp_off_side && !tt_rst |=> lead_err)
    else $error("slow leading ramp not caught");
  trail_cap_a: assert property (
    drv_rise && !ramp_off_side && !tt_rst |=> trail_err ##1 lead_err)
    else $error("slow trailing ramp not caught");
  tt_reset_a: assert property (
    tt_rst |=> !lead_err && !trail_err)
    else $error("transition flops not reset");
  fire_sel_a: assert property (
    dly_start && ctrl.undelayed_select |-> dur_trig)
    else $error("undelayed trigger missing");

  overlap_c: cover property (ev.overlap ##[1:20] sup_rst);
  delay_c: cover property (ev.delay);
  trail_c: cover property (drv_rise && !ramp_off_side);
  paired_c: cover property (
    ctrl.undelayed_select && ctrl.delayed_select && dly_end);

endmodule : ptd_core

// ===== core/ptd_pkg.sv
// constants and carrier types for the pulse timing error detector
package ptd_pkg;
  localparam int unsigned CLK_KHZ      = 200000;
  localparam int unsigned ERR_HOLD_MS  = 100;
  localparam int unsigned HOLD_CYC_DEF = ERR_HOLD_MS * CLK_KHZ;
  localparam int          HOLD_W       = 25;
  localparam int          DRV_DLY_DEF  = 4;
  localparam int          LEN_W_DEF    = 16;
  localparam logic [4:0]  CTRL_OFS     = 5'h00;
  localparam logic [4:0]  DLY_LEN_OFS  = 5'h04;
  localparam logic [4:0]  DUR_LEN_OFS  = 5'h08;
  localparam logic [4:0]  STATUS_OFS   = 5'h0C;
  localparam logic [4:0]  MASK_OFS     = 5'h10;
  localparam logic [4:0]  STATE_OFS    = 5'h14;
  localparam logic [2:0]  CTRL_RST     = 3'h1;
  localparam logic [3:0]  MASK_RST     = 4'h0;

  // ctrl bit 0 undelayed, bit 1 delayed, bit 2 duration gate
  typedef struct packed {
    logic dur_gate;
    logic delayed_select;
    logic undelayed_select;
  } ptd_ctrl_t;

  // status and mask: bit 0 overlap, 1 delay, 2 transition, 3 settings
  typedef struct packed {
    logic cfg;
    logic trans;
    logic delay;
    logic overlap;
  } ptd_evt_t;

  // read-only state word, bit 6 downward
  typedef struct packed {
    logic dly_act;
    logic dur_act;
    logic error_lamp;
    logic trail_err;
    logic lead_err;
    logic overlap;
    logic err_latch;
  } ptd_state_t;
endpackage : ptd_pkg

// ===== verif/ptd_far_side.sv
// far side model: trigger source and transition ramp comparator
`timescale 1ns/1ps
module ptd_far_side (
  input  wire logic       ref_clk,
  input  wire logic       fire,
  input  wire logic       dur_out,
  input  wire logic [5:0] lead_lag,
  output logic            trig_in,
  output logic            ramp_off_side
);
  logic [63:0] hist = '0;
  logic        ramp_on;
  // ramp starts one cycle after the delayed drive and needs a settable lag
  // to pass midpoint; it falls one cycle after the drive falls
  always_ff @(posedge ref_clk) begin
    trig_in <= fire;
    hist    <= {hist[62:0], dur_out};
  end
  assign ramp_on       = hist[4] & hist[6'd4 + lead_lag];
  assign ramp_off_side = ~ramp_on;
endmodule : ptd_far_side

// ===== verif/ptd_core_tb.sv
// self-checking testbench for the pulse timing error detector
`timescale 1ns/1ps
module ptd_core_tb
  import ptd_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        fire = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [5:0]  lead_lag = 6'h00;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest, trig_in, ramp_off_side;
  logic        dur_out, dur_out_n, error_lamp, irq;
  int          error_cnt = 0;
  int          compares = 0;
  int          hi, rises, bad, first;

  // short hold counts keep the run brief
  ptd_core #(.ERR_HOLD_CYC(16), .TT_HOLD_CYC(16)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trig_in(trig_in),
    .ramp_off_side(ramp_off_side), .dur_out(dur_out),
    .dur_out_n(dur_out_n), .error_lamp(error_lamp), .irq(irq));
  ptd_far_side far_u (.ref_clk(ref_clk), .fire(fire), .dur_out(dur_out),
    .lead_lag(lead_lag), .trig_in(trig_in), .ramp_off_side(ramp_off_side));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 50) chk("waitrequest", 0, 1);
  endtask : bus

  task rd_chk(input string what, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask : rd_chk

  task pulse;
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask : pulse

  task cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cycles

  task watch(input int win);
    logic prev;
    prev = dur_out;
    hi = 0;
    rises = 0;
    bad = 0;
    first = -1;
    for (int i = 0; i < win; i++) begin
      @(negedge ref_clk);
      if (dur_out === 1'b1) hi++;
      if (dur_out === 1'b1 && prev !== 1'b1) rises++;
      if (dur_out === 1'b1 && first < 0) first = i;
      if (dur_out_n === dur_out) bad++;
      prev = dur_out;
    end
  endtask : watch

  task t_regs;
    rd_chk("ctrl", CTRL_OFS, {29'h0, CTRL_RST});
    rd_chk("mask", MASK_OFS, {28'h0, MASK_RST});
    rd_chk("unmapped", 5'h1C, 32'h0);
    rd_chk("status", STATUS_OFS, 32'h8);
    bus(1'b1, DUR_LEN_OFS, 32'h3);
    bus(1'b1, STATUS_OFS, 32'hF);
    bus(1'b1, STATE_OFS, 32'h7F);
    rd_chk("state", STATE_OFS, 32'h0);
    rd_chk("status", STATUS_OFS, 32'h0);
    chk("lamp", 0, error_lamp);
    $display("test regs done");
  endtask : t_regs

  task t_pulse;
    pulse;
    watch(12);
    chk("rise", 2, first);
    chk("width", 3, hi);
    chk("compl", 0, bad);
    bus(1'b1, CTRL_OFS, 32'h5);
    pulse;
    watch(12);
    chk("gated", 0, hi);
    chk("gated_n", 12, bad);
    bus(1'b1, CTRL_OFS, 32'h1);
    $display("test pulse done");
  endtask : t_pulse

  task t_overlap;
    bus(1'b1, DUR_LEN_OFS, 32'hA);
    bus(1'b1, MASK_OFS, 32'h1);
    pulse;
    cycles(3);
    pulse;
    hi = 0;
    while (error_lamp !== 1'b1 && hi < 10) begin
      hi++;
      cycles(1);
    end
    hi = 0;
    repeat (30) begin
      if (error_lamp === 1'b1) hi++;
      cycles(1);
    end
    chk("hold", 16, hi);
    chk("irq", 1, irq);
    bus(1'b1, STATUS_OFS, 32'h1);
    cycles(2);
    chk("irq_clr", 0, irq);
    bus(1'b1, MASK_OFS, 32'h0);
    $display("test overlap done");
  endtask : t_overlap

  task t_delay;
    bus(1'b1, DLY_LEN_OFS, 32'hC);
    bus(1'b1, DUR_LEN_OFS, 32'h3);
    bus(1'b1, CTRL_OFS, 32'h2);
    pulse;
    watch(20);
    chk("delayed", 1, first >= 12 && first <= 14);
    bus(1'b1, CTRL_OFS, 32'h3);
    pulse;
    watch(24);
    chk("paired", 2, rises);
    bus(1'b1, CTRL_OFS, 32'h2);
    pulse;
    cycles(3);
    pulse;
    cycles(4);
    rd_chk("delay_err", STATUS_OFS, 32'h2);
    cycles(30);
    $display("test delay done");
  endtask : t_delay

  task t_trans;
    bus(1'b1, CTRL_OFS, 32'h1);
    bus(1'b1, DUR_LEN_OFS, 32'h6);
    bus(1'b1, STATUS_OFS, 32'hF);
    lead_lag <= 6'd20;
    pulse;
    cycles(16);
    chk("lamp", 1, error_lamp);
    rd_chk("trans", STATUS_OFS, 32'h4);
    lead_lag <= 6'd0;
    cycles(30);
    chk("lamp_off", 0, error_lamp);
    $display("test trans done");
  endtask : t_trans

  task test_done;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs;
    t_pulse;
    t_overlap;
    t_delay;
    t_trans;
    test_done;
  end

  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    test_done;
  end
endmodule : ptd_core_tb
